// *** hw/ufetx_fifo.sv ***
/*
 * synchronous fifo with valid/ready on both sides.
 * assumes a single clock and synchronous active-low reset.
 */
`timescale 1ns/10ps
module ufetx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] cnt_reg;
  logic [AW:0] cnt_next;
  logic push;
  logic pop;

  // =====================================================================
  // flags and handshakes
  assign cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
  assign out_valid = (cnt_reg != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr_reg];

  // storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg <= '0;
      in_ready <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      cnt_reg <= cnt_next;
      // ready means room after this edge, so a sender trusting it never overflows
      in_ready <= (cnt_next != (AW+1)'(DEPTH));
    end
  end
endmodule : ufetx_fifo

// *** hw/ufetx_pkg.sv ***
/*
 * types shared by the usb function / transmit endpoint register block.
 * assumes ufetx_regs.svh for the numeric encodings.
 */
package ufetx_pkg;
  // endpoint status encoding
  typedef enum logic [1:0] {
    UFETX_ST_DISABLED = 2'h0,
    UFETX_ST_STALL = 2'h1,
    UFETX_ST_NAK = 2'h2,
    UFETX_ST_VALID = 2'h3
  } ufetx_stat_e;

  // handshake chosen for a token
  typedef enum logic [1:0] {
    UFETX_HS_NONE = 2'h0,
    UFETX_HS_STALL = 2'h1,
    UFETX_HS_NAK = 2'h2,
    UFETX_HS_GO = 2'h3
  } ufetx_hs_e;

  typedef logic [7:0] ufetx_byte_t;
endpackage : ufetx_pkg

// *** hw/ufetx_regs.svh ***
/*
 * constants of the usb function / transmit endpoint register block:
 * register indexes, field positions, reset values, encodings.
 * assumes it is included by its bare name from design and bench files.
 */
`ifndef UFETX_REGS_SVH
`define UFETX_REGS_SVH

// =====================================================================
// register indexes inside the core register file
`define UFETX_FADDR_BASE 8'hF0
`define UFETX_EPTX_BASE 8'hF0
`define UFETX_FNH_ADDR 8'hFE
`define UFETX_FNL_ADDR 8'hFF
`define UFETX_RST_VAL 8'h00

// =====================================================================
// function address fields
`define UFETX_FEN_BIT 7

// =====================================================================
// transmit endpoint fields
`define UFETX_CTR_BIT 7
`define UFETX_TOG_BIT 6
`define UFETX_STAT_HI 5
`define UFETX_STAT_LO 4
`define UFETX_PID_HI 3
`define UFETX_PID_LO 2
`define UFETX_CEP_BIT 1
`define UFETX_ISO_BIT 0

// =====================================================================
// frame number high fields
`define UFETX_LOST_HI 4
`define UFETX_LOST_LO 3

// =====================================================================
// token pid top bits
`define UFETX_PID_OUT 2'h0
`define UFETX_PID_IN 2'h2
`define UFETX_PID_SETUP 2'h3

`endif

// *** hw/ufetx_top.sv ***
/*
 * usb function address, frame number and transmit endpoint registers,
 * plus a 16-word fifo in the transmit data path.
 * assumes the serial engine presents decoded token and transaction
 * events as one-cycle pulses on MCLK, and software reaches the
 * registers through the core register-file port (page select + index).
 */
`timescale 1ns/10ps
`include "ufetx_regs.svh"

// Overview of operation
// RULE1 - lost frame count increments on each missed frame, clears on frame received
// RULE2 - frame number bits 10:8 held in high frame register on frame event
// RULE3 - frame number bits 7:0 held in low frame register on frame event
// RULE4 - function address has enable in bit 7, address in 6:0
// RULE5 - function addresses clear on device reset, bus reset and forced reset
// RULE6 - endpoint registers clear on resets, flag survives a bus reset
// RULE7 - hardware sets transfer flag on successful transaction; software only clears
// RULE8 - no flag on nak, stall, protocol error or toggle mismatch
// RULE9 - flag set makes valid non-iso endpoint nak, setup ignored
// RULE10 - toggle picks data0/data1 and flips on host ack
// RULE11 - setup on control endpoint forces toggle to one
// RULE12 - iso endpoint toggle selects buffer, flips after each packet sent
// RULE13 - software initialises toggle before use on non-control endpoints
// RULE14 - status 00 disabled, 01 stall, 10 nak, 11 valid
// RULE15 - successful in or control setup sets status nak, iso unchanged
// RULE16 - captured pid field holds top two bits of last token
// RULE17 - captured pid frozen while transfer flag is set
// RULE18 - control endpoint with receive nak gives no answer to setup
// RULE19 - control endpoint with receive stall still accepts setup
// RULE20 - software uses only disabled or valid on iso endpoints
// RULE21 - iso toggle zero uses transmit buffer pair, one uses receive pair
// RULE22 - software never enables iso endpoint in both directions
// RULE23 - missed frame event flagged when expected frame absent
// RULE24 - receive status uses same encoding, consulted for setup handling
// RULE25 - writing one to transfer flag keeps it, zero clears it
module ufetx_top
  import ufetx_pkg::*;
#(
  parameter int FUNCS = 8,
  parameter int EPS = 8,
  parameter int FIFO_WIDTH = 8,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic [1:0] REG_PAGE,
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire ufetx_pkg::ufetx_byte_t REG_WDATA,
  output ufetx_pkg::ufetx_byte_t REG_RDATA,
  input wire logic FORCED_INTERFACE_RESET,
  input wire logic BUS_RESET,
  input wire logic FRAME_RECEIVED,
  input wire logic [10:0] FRAME_INDEX,
  input wire logic EXPECTED_FRAME_MISSED,
  input wire logic TOKEN_VALID,
  input wire logic [1:0] TOKEN_PID,
  input wire logic [2:0] TOKEN_EP,
  input wire logic [1:0] RX_STATUS,
  input wire logic TX_SENT,
  input wire logic HOST_ACK,
  input wire logic XFER_ERROR,
  input wire logic SETUP_DONE,
  output ufetx_pkg::ufetx_hs_e HANDSHAKE,
  output logic HANDSHAKE_VALID,
  output logic DATA_PID_ONE,
  output logic ISO_USE_RX_PAIR,
  input wire logic [FIFO_WIDTH-1:0] TX_DATA,
  input wire logic TX_DATA_VALID,
  output logic TX_DATA_READY,
  output logic [FIFO_WIDTH-1:0] SIE_DATA,
  output logic SIE_DATA_VALID,
  input wire logic SIE_DATA_READY
);
  import ufetx_pkg::*;

  localparam logic [1:0] PAGE_EP = 2'h0;
  localparam logic [1:0] PAGE_FUNC = 2'h1;

  ufetx_byte_t faddr_reg [FUNCS];
  ufetx_byte_t ep_reg [EPS];
  logic [1:0] lost_frame_count_reg;
  logic [10:0] frame_index_reg;
  logic [2:0] cur_ep_reg;
  logic [1:0] cur_pid_reg;
  logic in_progress_reg;
  logic clr_resets;
  ufetx_hs_e hs_next;
  ufetx_byte_t rdata_next;
  ufetx_byte_t cur_ep;
  logic [FIFO_WIDTH-1:0] fifo_data;
  logic fifo_valid;
  logic fifo_ready;

  // register index decode, used by the write and read paths
  function automatic logic hit(input logic [7:0] a, input logic [7:0] base, input int n,
                               output int idx);
    idx = 0;
    hit = 1'b0;
    if (a >= base && int'(a - base) < n) begin
      idx = int'(a - base);
      hit = 1'b1;
    end
  endfunction : hit

  // =====================================================================
  // reset sources for addresses and endpoint registers
  assign clr_resets = BUS_RESET || FORCED_INTERFACE_RESET;
  assign cur_ep = ep_reg[TOKEN_EP];

  // =====================================================================
  // frame tracking
  always_ff @(posedge MCLK) begin
    if (!RST_N || clr_resets) begin
      lost_frame_count_reg <= 2'h0;
      frame_index_reg <= 11'h000;
    end else if (FRAME_RECEIVED) begin
      lost_frame_count_reg <= 2'h0; // RULE1
      frame_index_reg <= FRAME_INDEX; // RULE2 RULE3
    end else if (EXPECTED_FRAME_MISSED) begin
      lost_frame_count_reg <= lost_frame_count_reg + 2'h1; // RULE1 RULE23
    end
  end

  // =====================================================================
  // function address registers
  generate
    for (genvar f = 0; f < FUNCS; f++) begin : g_func
      always_ff @(posedge MCLK) begin
        int idx;
        idx = 0;
        if (!RST_N || clr_resets) begin
          faddr_reg[f] <= `UFETX_RST_VAL; // RULE5
        end else if (REG_WR && REG_PAGE == PAGE_FUNC &&
                     hit(REG_ADDR, `UFETX_FADDR_BASE, FUNCS, idx) && idx == f) begin
          faddr_reg[f] <= REG_WDATA; // RULE4
        end
      end
    end
  endgenerate

  // =====================================================================
  // handshake choice for a token addressed to an endpoint
  always_comb begin
    hs_next = UFETX_HS_GO;
    if (cur_ep[`UFETX_ISO_BIT]) begin
      hs_next = (cur_ep[`UFETX_STAT_HI:`UFETX_STAT_LO] == 2'h3) ? UFETX_HS_GO : UFETX_HS_NONE;
    end else if (TOKEN_PID == `UFETX_PID_SETUP) begin
      if (!cur_ep[`UFETX_CEP_BIT] || RX_STATUS == 2'h0) begin
        hs_next = UFETX_HS_NONE; // RULE24
      end else if (RX_STATUS == 2'h2) begin
        hs_next = UFETX_HS_NONE; // RULE18
      end else if (cur_ep[`UFETX_CTR_BIT]) begin
        hs_next = UFETX_HS_NONE; // RULE9
      end else begin
        hs_next = UFETX_HS_GO; // RULE19
      end
    end else begin
      case (ufetx_stat_e'(cur_ep[`UFETX_STAT_HI:`UFETX_STAT_LO])) // RULE14
        UFETX_ST_DISABLED: hs_next = UFETX_HS_NONE;
        UFETX_ST_STALL: hs_next = UFETX_HS_STALL;
        UFETX_ST_NAK: hs_next = UFETX_HS_NAK;
        UFETX_ST_VALID: hs_next = cur_ep[`UFETX_CTR_BIT] ? UFETX_HS_NAK : UFETX_HS_GO; // RULE9
        default: hs_next = UFETX_HS_NONE;
      endcase
    end
  end

  // =====================================================================
  // handshake outputs and current transaction tracking
  always_ff @(posedge MCLK) begin
    if (!RST_N || clr_resets) begin
      HANDSHAKE <= UFETX_HS_NONE;
      HANDSHAKE_VALID <= 1'b0;
      cur_ep_reg <= 3'h0;
      cur_pid_reg <= 2'h0;
      in_progress_reg <= 1'b0;
    end else begin
      HANDSHAKE_VALID <= TOKEN_VALID;
      if (TOKEN_VALID) begin
        HANDSHAKE <= hs_next;
        cur_ep_reg <= TOKEN_EP;
        cur_pid_reg <= TOKEN_PID;
        in_progress_reg <= (hs_next == UFETX_HS_GO);
      end else if (HOST_ACK || TX_SENT || SETUP_DONE || XFER_ERROR) begin
        in_progress_reg <= 1'b0;
      end
    end
  end

  // =====================================================================
  // transmit endpoint registers
  generate
    for (genvar e = 0; e < EPS; e++) begin : g_ep
      always_ff @(posedge MCLK) begin
        int idx;
        logic iso;
        logic ok;
        idx = 0;
        iso = ep_reg[e][`UFETX_ISO_BIT];
        ok = in_progress_reg && cur_ep_reg == 3'(e) && !XFER_ERROR; // RULE8
        // forced reset clears the whole register, a bus reset keeps the flag
        if (!RST_N || FORCED_INTERFACE_RESET) begin
          ep_reg[e] <= `UFETX_RST_VAL; // RULE6
        end else if (BUS_RESET) begin
          ep_reg[e] <= {ep_reg[e][`UFETX_CTR_BIT], 7'h00}; // RULE6
        end else begin
          if (REG_WR && REG_PAGE == PAGE_EP &&
              hit(REG_ADDR, `UFETX_EPTX_BASE, EPS, idx) && idx == e) begin
            ep_reg[e][`UFETX_TOG_BIT:`UFETX_STAT_LO] <= REG_WDATA[6:4]; // RULE13 RULE20
            ep_reg[e][1:0] <= REG_WDATA[1:0];
            if (!REG_WDATA[`UFETX_CTR_BIT]) begin
              ep_reg[e][`UFETX_CTR_BIT] <= 1'b0; // RULE25
            end
          end
          if (TOKEN_VALID && TOKEN_EP == 3'(e) && !ep_reg[e][`UFETX_CTR_BIT]) begin
            ep_reg[e][`UFETX_PID_HI:`UFETX_PID_LO] <= TOKEN_PID; // RULE16 RULE17
          end
          if (TOKEN_VALID && TOKEN_EP == 3'(e) && ep_reg[e][`UFETX_CEP_BIT] &&
              TOKEN_PID == `UFETX_PID_SETUP && hs_next == UFETX_HS_GO) begin
            ep_reg[e][`UFETX_TOG_BIT] <= 1'b1; // RULE11
          end
          if (ok && iso && TX_SENT) begin
            ep_reg[e][`UFETX_TOG_BIT] <= !ep_reg[e][`UFETX_TOG_BIT]; // RULE12
            ep_reg[e][`UFETX_CTR_BIT] <= 1'b1; // RULE7
          end
          if (ok && !iso && HOST_ACK && cur_pid_reg == `UFETX_PID_IN) begin
            ep_reg[e][`UFETX_TOG_BIT] <= !ep_reg[e][`UFETX_TOG_BIT]; // RULE10
            ep_reg[e][`UFETX_STAT_HI:`UFETX_STAT_LO] <= UFETX_ST_NAK; // RULE15
            ep_reg[e][`UFETX_CTR_BIT] <= 1'b1; // RULE7
          end
          if (ok && !iso && SETUP_DONE && cur_pid_reg == `UFETX_PID_SETUP) begin
            ep_reg[e][`UFETX_STAT_HI:`UFETX_STAT_LO] <= UFETX_ST_NAK; // RULE15
            ep_reg[e][`UFETX_CTR_BIT] <= 1'b1; // RULE7
          end
        end
      end
    end
  endgenerate

  // =====================================================================
  // data pid and iso buffer selection for the endpoint in use
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      DATA_PID_ONE <= 1'b0;
      ISO_USE_RX_PAIR <= 1'b0;
    end else begin
      DATA_PID_ONE <= !ep_reg[cur_ep_reg][`UFETX_ISO_BIT] &&
                      ep_reg[cur_ep_reg][`UFETX_TOG_BIT]; // RULE10
      ISO_USE_RX_PAIR <= ep_reg[cur_ep_reg][`UFETX_ISO_BIT] &&
                         ep_reg[cur_ep_reg][`UFETX_TOG_BIT]; // RULE21
    end
  end

  // =====================================================================
  // register read path
  always_comb begin
    int idx;
    idx = 0;
    rdata_next = 8'h00;
    if (REG_PAGE == PAGE_EP && hit(REG_ADDR, `UFETX_EPTX_BASE, EPS, idx)) begin
      rdata_next = ep_reg[idx];
    end else if (REG_PAGE == PAGE_FUNC && hit(REG_ADDR, `UFETX_FADDR_BASE, FUNCS, idx)) begin
      rdata_next = faddr_reg[idx];
    end else if (REG_PAGE == PAGE_FUNC && REG_ADDR == `UFETX_FNH_ADDR) begin
      rdata_next = {3'h0, lost_frame_count_reg, frame_index_reg[10:8]};
    end else if (REG_PAGE == PAGE_FUNC && REG_ADDR == `UFETX_FNL_ADDR) begin
      rdata_next = frame_index_reg[7:0];
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RD) begin
      REG_RDATA <= rdata_next;
    end
  end

  // =====================================================================
  // transmit data fifo, output side registered
  ufetx_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(MCLK),
    .rst_n(RST_N),
    .in_data(TX_DATA),
    .in_valid(TX_DATA_VALID),
    .in_ready(fifo_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(!SIE_DATA_VALID || SIE_DATA_READY)
  );

  // input ready is a flop inside the fifo that already means room next cycle
  assign TX_DATA_READY = fifo_ready;

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      SIE_DATA_VALID <= 1'b0;
      SIE_DATA <= '0;
    end else begin
      if (!SIE_DATA_VALID || SIE_DATA_READY) begin
        SIE_DATA_VALID <= fifo_valid;
        SIE_DATA <= fifo_data;
      end
    end
  end
endmodule : ufetx_top

// *** sim/ufetx_host_model.sv ***
/*
 * host side seen through the serial engine: tokens and completion pulses.
 * assumes send is called just after a falling edge of MCLK.
 */
`timescale 1ns/10ps
// ==========
// host model
module ufetx_host_model (
  input wire logic MCLK,
  output logic TOKEN_VALID,
  output logic [1:0] TOKEN_PID,
  output logic [2:0] TOKEN_EP,
  output logic [1:0] RX_STATUS,
  output logic TX_SENT,
  output logic HOST_ACK,
  output logic XFER_ERROR,
  output logic SETUP_DONE
);
  // idle lines at time zero
  initial begin
    {TOKEN_VALID, TOKEN_PID, TOKEN_EP, RX_STATUS} = 8'h00;
    {TX_SENT, HOST_ACK, XFER_ERROR, SETUP_DONE} = 4'h0;
  end
  // token, gap, then completion: 1 ack, 2 setup done, 3 sent, 4 ack with error
  task automatic send(input logic [1:0] pid, input logic [2:0] ep, input logic [1:0] rxs,
      input int kind, input int gap);
    TOKEN_VALID = 1'b1;
    TOKEN_PID = pid;
    TOKEN_EP = ep;
    RX_STATUS = rxs;
    @(negedge MCLK);
    TOKEN_VALID = 1'b0;
    // released fields show the inverse, not the stale value
    {TOKEN_PID, TOKEN_EP, RX_STATUS} = ~{pid, ep, rxs};
    repeat (gap) @(negedge MCLK);
    HOST_ACK = (kind == 1 || kind == 4);
    SETUP_DONE = (kind == 2);
    TX_SENT = (kind == 3);
    XFER_ERROR = (kind == 4);
    @(negedge MCLK);
    {TX_SENT, HOST_ACK, XFER_ERROR, SETUP_DONE} = 4'h0;
    @(negedge MCLK);
  endtask : send
endmodule : ufetx_host_model

// *** sim/ufetx_top_asserts.sv ***
/*
 * port checker for ufetx_top: frame, reset, read-back, handshake, fifo.
 * assumes it is bound into ufetx_top, one clock MCLK, sync RST_N.
 */
`timescale 1ns/10ps
// ==========
// checker
module ufetx_top_asserts
  import ufetx_pkg::*;
#(parameter int FIFO_WIDTH = 8) (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic [1:0] REG_PAGE,
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_RD,
  input wire ufetx_pkg::ufetx_byte_t REG_RDATA,
  input wire logic FORCED_INTERFACE_RESET,
  input wire logic BUS_RESET,
  input wire logic FRAME_RECEIVED,
  input wire logic [10:0] FRAME_INDEX,
  input wire logic EXPECTED_FRAME_MISSED,
  input wire logic TOKEN_VALID,
  input wire ufetx_pkg::ufetx_hs_e HANDSHAKE,
  input wire logic HANDSHAKE_VALID,
  input wire logic [FIFO_WIDTH-1:0] SIE_DATA,
  input wire logic SIE_DATA_VALID,
  input wire logic SIE_DATA_READY
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  logic usb_rst;
  // either interface reset source
  assign usb_rst = BUS_RESET | FORCED_INTERFACE_RESET;
  // page 1 read taken one cycle after a frame event
  sequence frame_rd(logic [7:0] a);
    $past(RST_N, 2) && $past(FRAME_RECEIVED, 2) && $past(REG_RD) && $past(REG_PAGE) == 2'h1
      && $past(REG_ADDR) == a && !$past(usb_rst) && !$past(usb_rst, 2);
  endsequence
  // read of the eight low registers of a page while reset is held
  sequence clr_rd(logic [1:0] p);
    $past(REG_RD) && $past(REG_PAGE) == p && ($past(REG_ADDR) & 8'hF8) == 8'hF0
      && $past(usb_rst) && $past(usb_rst, 2);
  endsequence
  frame_low_a: assert property (frame_rd(8'hFF) |-> REG_RDATA == 8'($past(FRAME_INDEX, 2)))
    else $error("frame low register mismatch");
  frame_high_a: assert property (frame_rd(8'hFE) ##0 !$past(EXPECTED_FRAME_MISSED, 2)
    |-> REG_RDATA[4:0] == {2'h0, 3'($past(FRAME_INDEX, 2) >> 8)})
    else $error("frame high register mismatch");
  addr_clear_a: assert property (clr_rd(2'h1) |-> REG_RDATA == 8'h00)
    else $error("function address not cleared");
  ep_clear_a: assert property (clr_rd(2'h0) |-> REG_RDATA[6:0] == 7'h00)
    else $error("endpoint register not cleared");
  forced_flag_a: assert property (clr_rd(2'h0) ##0 $past(FORCED_INTERFACE_RESET, 2)
    |-> REG_RDATA == 8'h00)
    else $error("forced reset kept the transfer flag");
  unmapped_zero_a: assert property ($past(REG_RD) && $past(REG_PAGE) >= 2'h2 |-> REG_RDATA == 8'h00)
    else $error("unmapped read not zero");
  hs_cause_a: assert property (HANDSHAKE_VALID |-> $past(TOKEN_VALID))
    else $error("handshake without token");
  hs_hold_a: assert property ($past(RST_N) && !$past(TOKEN_VALID) && !$past(usb_rst)
    |-> $stable(HANDSHAKE))
    else $error("handshake changed without token");
  fifo_hold_a: assert property (SIE_DATA_VALID && !SIE_DATA_READY
    |=> SIE_DATA_VALID && $stable(SIE_DATA))
    else $error("fifo output dropped while stalled");
  cover property (HANDSHAKE_VALID && HANDSHAKE == UFETX_HS_GO);
  cover property (frame_rd(8'hFE));
  cover property (SIE_DATA_VALID && !SIE_DATA_READY ##1 SIE_DATA_READY);
endmodule : ufetx_top_asserts

bind ufetx_top ufetx_top_asserts #(.FIFO_WIDTH(FIFO_WIDTH)) u_chk (.MCLK(MCLK), .RST_N(RST_N),
  .REG_PAGE(REG_PAGE), .REG_ADDR(REG_ADDR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
  .FORCED_INTERFACE_RESET(FORCED_INTERFACE_RESET), .BUS_RESET(BUS_RESET),
  .FRAME_RECEIVED(FRAME_RECEIVED), .FRAME_INDEX(FRAME_INDEX),
  .EXPECTED_FRAME_MISSED(EXPECTED_FRAME_MISSED), .TOKEN_VALID(TOKEN_VALID),
  .HANDSHAKE(HANDSHAKE), .HANDSHAKE_VALID(HANDSHAKE_VALID), .SIE_DATA(SIE_DATA),
  .SIE_DATA_VALID(SIE_DATA_VALID), .SIE_DATA_READY(SIE_DATA_READY));

// *** sim/ufetx_top_tb.sv ***
/*
 * self-checking bench for ufetx_top with a host model on the token side.
 * assumes 10 MHz MCLK, inputs driven at the falling edge.
 */
`timescale 1ns/10ps
`include "ufetx_regs.svh"
// ==========
// bench
module ufetx_top_tb;
  import ufetx_pkg::*;
  logic MCLK, RST_N, REG_WR, REG_RD, FORCED_INTERFACE_RESET, BUS_RESET, FRAME_RECEIVED;
  logic EXPECTED_FRAME_MISSED, TOKEN_VALID, TX_SENT, HOST_ACK, XFER_ERROR, SETUP_DONE;
  logic HANDSHAKE_VALID, DATA_PID_ONE, ISO_USE_RX_PAIR, TX_DATA_VALID, TX_DATA_READY;
  logic SIE_DATA_VALID, SIE_DATA_READY, took;
  logic rd_seen = 1'b0;
  logic [1:0] REG_PAGE, TOKEN_PID, RX_STATUS;
  logic [2:0] TOKEN_EP;
  logic [10:0] FRAME_INDEX, fi;
  logic [7:0] REG_ADDR, TX_DATA, SIE_DATA, d, m;
  ufetx_byte_t REG_WDATA, REG_RDATA;
  ufetx_hs_e HANDSHAKE;
  logic [7:0] rq[$], rm[$], fq[$];
  ufetx_hs_e hq[$];
  int n_errors = 0, compares = 0, seed = 2497, k, acc;

  ufetx_top uut (.MCLK(MCLK), .RST_N(RST_N), .REG_PAGE(REG_PAGE), .REG_ADDR(REG_ADDR),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .FORCED_INTERFACE_RESET(FORCED_INTERFACE_RESET), .BUS_RESET(BUS_RESET),
    .FRAME_RECEIVED(FRAME_RECEIVED), .FRAME_INDEX(FRAME_INDEX),
    .EXPECTED_FRAME_MISSED(EXPECTED_FRAME_MISSED), .TOKEN_VALID(TOKEN_VALID),
    .TOKEN_PID(TOKEN_PID), .TOKEN_EP(TOKEN_EP), .RX_STATUS(RX_STATUS), .TX_SENT(TX_SENT),
    .HOST_ACK(HOST_ACK), .XFER_ERROR(XFER_ERROR), .SETUP_DONE(SETUP_DONE),
    .HANDSHAKE(HANDSHAKE), .HANDSHAKE_VALID(HANDSHAKE_VALID), .DATA_PID_ONE(DATA_PID_ONE),
    .ISO_USE_RX_PAIR(ISO_USE_RX_PAIR), .TX_DATA(TX_DATA), .TX_DATA_VALID(TX_DATA_VALID),
    .TX_DATA_READY(TX_DATA_READY), .SIE_DATA(SIE_DATA), .SIE_DATA_VALID(SIE_DATA_VALID),
    .SIE_DATA_READY(SIE_DATA_READY));
  ufetx_host_model host (.MCLK(MCLK), .TOKEN_VALID(TOKEN_VALID), .TOKEN_PID(TOKEN_PID),
    .TOKEN_EP(TOKEN_EP), .RX_STATUS(RX_STATUS), .TX_SENT(TX_SENT), .HOST_ACK(HOST_ACK),
    .XFER_ERROR(XFER_ERROR), .SETUP_DONE(SETUP_DONE));

  // 100 ns clock
  initial begin
    MCLK = 1'b0;
    forever #50 MCLK = ~MCLK;
  end

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic results;
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results

  // register cycles, entered just after a falling edge
  task automatic wr(input logic [1:0] p, input logic [7:0] a, input logic [7:0] v);
    {REG_PAGE, REG_ADDR, REG_WDATA, REG_WR} = {p, a, v, 1'b1};
    @(negedge MCLK);
    REG_WR = 1'b0;
    @(negedge MCLK);
  endtask : wr
  task automatic rd(input logic [1:0] p, input logic [7:0] a, input logic [7:0] e,
      input logic [7:0] msk);
    rq.push_back(e);
    rm.push_back(msk);
    {REG_PAGE, REG_ADDR, REG_RD} = {p, a, 1'b1};
    @(negedge MCLK);
    REG_RD = 1'b0;
    @(negedge MCLK);
  endtask : rd
  task automatic tok(input logic [1:0] pid, input logic [2:0] ep, input logic [1:0] rxs,
      input int kind, input logic [1:0] hs);
    if (hs != 2'h0) hq.push_back(ufetx_hs_e'(hs));
    host.send(pid, ep, rxs, kind, 1 + int'($unsigned($random(seed)) % 3));
  endtask : tok
  task automatic frame(input logic [10:0] f);
    {FRAME_INDEX, FRAME_RECEIVED} = {f, 1'b1};
    @(negedge MCLK);
    {FRAME_INDEX, FRAME_RECEIVED} = {~f, 1'b0};
  endtask : frame

  // result watcher: oldest note against each read, handshake and fifo word
  always @(posedge MCLK) begin
    if (rd_seen) begin
      m = rm.pop_front();
      chk("read data", REG_RDATA & m, rq.pop_front() & m);
    end
    rd_seen <= REG_RD;
    if (HANDSHAKE_VALID === 1'b1 && HANDSHAKE !== UFETX_HS_NONE) begin
      if (hq.size() == 0) chk("spurious handshake", 8'(HANDSHAKE), 8'h00);
      else chk("handshake", 8'(HANDSHAKE), 8'(hq.pop_front()));
    end
    if (SIE_DATA_VALID === 1'b1 && SIE_DATA_READY) begin
      if (fq.size() == 0) chk("spurious fifo word", SIE_DATA, 8'h00);
      else chk("fifo word", SIE_DATA, fq.pop_front());
    end
  end

  // hang guard
  initial begin
    repeat (20000) @(posedge MCLK);
    chk("run time", 8'h00, 8'h01);
    results();
  end

  // main sequence
  initial begin
    {REG_WR, REG_RD, FORCED_INTERFACE_RESET, BUS_RESET, FRAME_RECEIVED} = 5'h00;
    {EXPECTED_FRAME_MISSED, REG_PAGE, REG_ADDR, REG_WDATA, FRAME_INDEX} = 30'h0;
    {TX_DATA, TX_DATA_VALID, SIE_DATA_READY} = 10'h000;
    RST_N = 1'b0;
    repeat (16) @(negedge MCLK);
    RST_N = 1'b1;
    @(negedge MCLK);
    for (int i = 0; i < 8; i++) begin
      rd(2'h1, 8'hF0 + 8'(i), 8'h00, 8'hFF);
      rd(2'h0, 8'hF0 + 8'(i), 8'h00, 8'hFF);
      d = 8'($random(seed));
      wr(2'h1, 8'hF0 + 8'(i), d);
      rd(2'h1, 8'hF0 + 8'(i), d, 8'hFF);
    end
    rd(2'h1, 8'hF8, 8'h00, 8'hFF);
    rd(2'h2, 8'hF0, 8'h00, 8'hFF);
    wr(2'h1, 8'hFE, 8'hFF);
    // missed frames count up; a received frame clears them and loads the index
    repeat (2) begin
      repeat (3) begin
        EXPECTED_FRAME_MISSED = 1'b1;
        @(negedge MCLK);
        EXPECTED_FRAME_MISSED = 1'b0;
        @(negedge MCLK);
      end
      rd(2'h1, 8'hFE, 8'h18, 8'h18);
      fi = 11'($random(seed));
      frame(fi);
      rd(2'h1, 8'hFE, {5'h00, fi[10:8]}, 8'h1F);
      frame(fi);
      rd(2'h1, 8'hFF, fi[7:0], 8'hFF);
    end
    // every transmit status code on a bulk endpoint
    for (int s = 0; s < 4; s++) begin
      wr(2'h0, 8'hF1, {2'h0, 2'(s), 4'h0});
      tok(`UFETX_PID_IN, 3'h1, 2'h3, (s == 3) ? 1 : 0, 2'(s));
      rd(2'h0, 8'hF1, (s == 3) ? 8'hE8 : {2'h0, 2'(s), 4'h0}, (s == 3) ? 8'hFF : 8'hF3);
    end
    // flag set: nak, pid frozen, a written one keeps it, a zero clears it
    wr(2'h0, 8'hF1, 8'hF0);
    rd(2'h0, 8'hF1, 8'hF8, 8'hFF);
    tok(`UFETX_PID_IN, 3'h1, 2'h3, 0, 2'h2);
    tok(`UFETX_PID_OUT, 3'h1, 2'h3, 0, 2'h2);
    rd(2'h0, 8'hF1, 8'hF8, 8'hFF);
    wr(2'h0, 8'hF1, 8'h70);
    rd(2'h0, 8'hF1, 8'h78, 8'hFF);
    tok(`UFETX_PID_IN, 3'h1, 2'h3, 4, 2'h3);
    rd(2'h0, 8'hF1, 8'h78, 8'hFF);
    chk("data pid one", {7'h00, DATA_PID_ONE}, 8'h01);
    // control endpoint setup handling
    wr(2'h0, 8'hF2, 8'h32);
    tok(`UFETX_PID_SETUP, 3'h2, 2'h1, 2, 2'h3);
    rd(2'h0, 8'hF2, 8'hEE, 8'hFF);
    tok(`UFETX_PID_SETUP, 3'h2, 2'h3, 0, 2'h0);
    wr(2'h0, 8'hF2, 8'h32);
    rd(2'h0, 8'hF2, 8'h3E, 8'hFF);
    tok(`UFETX_PID_SETUP, 3'h2, 2'h2, 0, 2'h0);
    rd(2'h0, 8'hF2, 8'h3E, 8'hBF);
    // isochronous endpoint swaps buffers, status kept
    wr(2'h0, 8'hF3, 8'h31);
    tok(`UFETX_PID_IN, 3'h3, 2'h3, 3, 2'h3);
    rd(2'h0, 8'hF3, 8'hF9, 8'hFF);
    chk("iso buffer select", {7'h00, ISO_USE_RX_PAIR}, 8'h01);
    // bus reset keeps the flag, forced reset does not
    BUS_RESET = 1'b1;
    @(negedge MCLK);
    rd(2'h1, 8'hF0, 8'h00, 8'hFF);
    rd(2'h0, 8'hF3, 8'h80, 8'hFF);
    {BUS_RESET, FORCED_INTERFACE_RESET} = 2'h1;
    @(negedge MCLK);
    rd(2'h0, 8'hF3, 8'h00, 8'hFF);
    FORCED_INTERFACE_RESET = 1'b0;
    // fill the fifo with the far side stalled, then drain at a random pace
    {TX_DATA, TX_DATA_VALID} = {8'($random(seed)), 1'b1};
    acc = 0;
    k = 0;
    while (acc < 3 && k < 60) begin
      @(posedge MCLK);
      took = (TX_DATA_READY === 1'b1);
      if (took) fq.push_back(TX_DATA);
      else acc++;
      @(negedge MCLK);
      k++;
      if (took) TX_DATA = 8'($random(seed));
    end
    TX_DATA_VALID = 1'b0;
    if (k == 60) chk("fifo never full", 8'h00, 8'h01);
    k = 0;
    while (fq.size() > 0 && k < 400) begin
      SIE_DATA_READY = 1'($random(seed));
      @(negedge MCLK);
      k++;
    end
    if (k == 400) chk("fifo never drained", 8'h00, 8'h01);
    repeat (4) @(negedge MCLK);
    results();
  end
endmodule : ufetx_top_tb
